// ### core/sceg_map.vh
// sceg_map.vh - register indices, field positions, reset values and
// guard constants for the smart card etu / checksum / guard block.
// assumes: included by core/sceg_top.v only; definitions only.
`ifndef SCEG_MAP_VH
`define SCEG_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address on apb is four times the index)
// ----------------------------------------------------------------------
`define SCEG_IDX_W          16
`define SCEG_IDX_CSUM_HI    16'hFE14
`define SCEG_IDX_CSUM_LO    16'hFE15
`define SCEG_IDX_GUARD      16'hFE16
`define SCEG_IDX_SPACING    16'hFE17
`define SCEG_IDX_BWAIT3     16'hFE18
`define SCEG_IDX_BWAIT2     16'hFE19
`define SCEG_IDX_BWAIT1     16'hFE1A
`define SCEG_IDX_BWAIT0     16'hFE1B
`define SCEG_IDX_CTL        16'hFE30
`define SCEG_IDX_STAT       16'hFE31

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCEG_RST_CSUM_HI    8'hFF
`define SCEG_RST_CSUM_LO    8'hFF
`define SCEG_RST_GUARD      8'h10
`define SCEG_RST_SPACING    8'h0C
`define SCEG_RST_BWAIT      8'h00
`define SCEG_RST_CTL        3'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SCEG_GUARD_SPMSB    7
`define SCEG_GUARD_TURN_HI  4
`define SCEG_BWAIT3_HI      3
`define SCEG_CTL_BLOCK      0
`define SCEG_CTL_CRC        1
`define SCEG_CTL_GEN        2

// ----------------------------------------------------------------------
// checksum and guard constants
// ----------------------------------------------------------------------
`define SCEG_CRC_POLY       16'h1021
`define SCEG_MIN_SP_CHAR    9'h00C
`define SCEG_MIN_SP_BLOCK   9'h00B
`define SCEG_CNT_MAX        9'h1FF
`define SCEG_ETU_W          13

`endif

// ### core/sceg_top.v
// sceg_top.v - etu divider, crc/lrc checksum unit, transmit guard timing
// and block wait registers of a smart card character interface.
// assumes: the uart framer, rx fifo and wait counters share pclk; the
// uart hands over bytes already in direct convention.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "sceg_map.vh"

// Functional notes
// - etu divider uses the table value where Fi code meets Di code
// - checksum register seeds tx; check bytes sent after last byte if enabled in block mode
// - crc uses polynomial x^16 + x^12 + x^5 + 1
// - rx runs over data and check bytes; firmware tests 0x1D0F or zero
// - lrc uses only the low checksum byte; high byte undefined
// - running checksum value stays readable at all times
// - received check bytes go to the rx fifo with the data
// - checksum works on direct-convention bytes either way
// - checksum updates on taken tx data and rx bytes, whatever mode or enable; not on own check bytes, nor on an rx byte in a tx take cycle
// - check bytes keep the ordinary character spacing
// - first tx character waits turnaround guard from last rx start bit
// - nine-bit extra spacing, floored at 12 etu (11 in block mode), is the least gap between tx start bits
// - wait limit held in four bytes, lowest byte at highest index
// - etu from master clock over twice Fi/Di; card clock is half
// - 28-bit wait limit feeds block or work wait counting
module sceg_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [3:0]  fi_code,
  input  wire [3:0]  di_code,
  output reg         etu_tick,
  output reg         card_clk,
  input  wire        tx_valid,
  input  wire [7:0]  tx_data,
  input  wire        tx_last,
  output wire        tx_ready,
  input  wire        ch_ready,
  output reg         ch_start,
  output reg  [7:0]  ch_data,
  input  wire        rx_start,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        break_det,
  output reg         rxf_valid,
  output reg  [7:0]  rxf_data,
  output wire [27:0] block_wait_limit
);
  // ----------------------------------------------------------------------
  // one-hot transmit states
  // ----------------------------------------------------------------------
  localparam [2:0] ST_DATA = 3'b001;
  localparam [2:0] ST_CHI  = 3'b010;
  localparam [2:0] ST_CLO  = 3'b100;
  reg [7:0]             csum_hi_q;
  reg [7:0]             csum_lo_q;
  reg [7:0]             guard_q;
  reg [7:0]             spacing_q;
  reg [7:0]             bwait_q [0:3];
  reg [2:0]             ctl_q;
  reg [2:0]             st_q;
  reg [15:0]            tx_word_q;
  reg [`SCEG_ETU_W-1:0] etu_cnt_q;
  reg [`SCEG_ETU_W-1:0] etu_div_q;
  reg [8:0]             since_tx_q;
  reg [8:0]             since_rx_q;
  reg                   first_q;
  reg [15:0]            csum_d;
  reg [8:0]             min_sp;
  reg [8:0]             space_req;
  wire [15:0] idx      = paddr[17:2];
  wire        wr_en    = psel & penable & pwrite;
  wire        block_md = ctl_q[`SCEG_CTL_BLOCK];
  wire        crc_md   = ctl_q[`SCEG_CTL_CRC];
  wire        gen_en   = ctl_q[`SCEG_CTL_GEN];
  wire [8:0]  spacing9 = {guard_q[`SCEG_GUARD_SPMSB], spacing_q};
  wire [8:0]  turn9    = {4'h0, guard_q[`SCEG_GUARD_TURN_HI:0]};
  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // divider = round(2 * Fi / Di); rounding reproduces the ratio table
  function [`SCEG_ETU_W-1:0] etu_ratio;
    input [3:0] fc;
    input [3:0] dc;
    integer f, d, r;
    begin
      case (fc)
        4'h0, 4'h1: f = 372;
        4'h2:       f = 558;
        4'h3:       f = 744;
        4'h4:       f = 1116;
        4'h5:       f = 1488;
        4'h6, 4'h7: f = 1860;
        4'h8, 4'h9: f = 512;
        4'hA:       f = 768;
        4'hB:       f = 1024;
        4'hC:       f = 1536;
        default:    f = 2048;
      endcase
      case (dc)
        4'h0, 4'h1: d = 1;
        4'h2:       d = 2;
        4'h3:       d = 4;
        4'h4:       d = 8;
        4'h5:       d = 16;
        4'h6, 4'h7: d = 32;
        4'h8:       d = 12;
        4'h9:       d = 20;
        default:    d = 16;
      endcase
      r = (2 * f + d / 2) / d;
      etu_ratio = r[`SCEG_ETU_W-1:0];
    end
  endfunction
  // one byte through crc (msb first) or lrc (low byte xor)
  function [15:0] csum_step;
    input [15:0] c;
    input [7:0]  b;
    input        crc;
    integer i;
    reg [15:0] t;
    reg        fb;
    begin
      t = c;
      if (crc) begin
        for (i = 7; i >= 0; i = i - 1) begin
          fb = t[15] ^ b[i];
          t  = {t[14:0], 1'b0};
          if (fb)
            t = t ^ `SCEG_CRC_POLY;
        end
      end else begin
        t[7:0] = t[7:0] ^ b;
      end
      csum_step = t;
    end
  endfunction
  // saturating etu count, cleared by its own event
  function [8:0] etu_count;
    input [8:0] v;
    input       clr;
    input       tick;
    begin
      if (clr)
        etu_count = 9'h000;
      else if (tick && v != `SCEG_CNT_MAX)
        etu_count = v + 9'h001;
      else
        etu_count = v;
    end
  endfunction
  // ----------------------------------------------------------------------
  // etu divider and card clock
  // ----------------------------------------------------------------------
  // card_master_clock is pclk; the ratio is reloaded every pclk, so a code change
  // takes effect one cycle later, mid-etu, shortening or stretching the etu in progress
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      etu_div_q <= {`SCEG_ETU_W{1'b1}};
      etu_cnt_q <= {`SCEG_ETU_W{1'b0}};
      etu_tick  <= 1'b0;
      card_clk  <= 1'b0;
    end else begin
      etu_div_q <= etu_ratio(fi_code, di_code);
      card_clk  <= ~card_clk;
      if (etu_cnt_q >= etu_div_q - 1'b1) begin
        etu_cnt_q <= {`SCEG_ETU_W{1'b0}};
        etu_tick  <= 1'b1;
      end else begin
        etu_cnt_q <= etu_cnt_q + 1'b1;
        etu_tick  <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------------
  // guard timing
  // ----------------------------------------------------------------------
  // spacing floor applies whatever smaller value software loaded
  always @* begin
    min_sp    = block_md ? `SCEG_MIN_SP_BLOCK : `SCEG_MIN_SP_CHAR;
    space_req = (spacing9 > min_sp) ? spacing9 : min_sp;
  end
  wire guard_ok = (since_tx_q >= space_req) &&
                  (!first_q || since_rx_q >= turn9);
  wire send_go  = guard_ok & ch_ready;
  assign tx_ready = st_q[0] & send_go;
  // start strobe is needed by the guard counters, so it is declared ahead of them
  wire       take_data  = tx_ready & tx_valid;
  wire       ch_start_d = take_data | ((st_q[1] | st_q[2]) & send_go);
  wire [7:0] chk_byte   = st_q[1] ? tx_word_q[15:8] : tx_word_q[7:0];
  // a break in char mode restarts the spacing count from the break
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_tx_q <= `SCEG_CNT_MAX;
      since_rx_q <= `SCEG_CNT_MAX;
      first_q    <= 1'b0;
    end else begin
      since_tx_q <= etu_count(since_tx_q, ch_start_d |
                              (break_det & ~block_md), etu_tick);
      since_rx_q <= etu_count(since_rx_q, rx_start, etu_tick);
      if (rx_start)
        first_q <= 1'b1;
      else if (ch_start_d)
        first_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // transmit sequencing
  // ----------------------------------------------------------------------
  // check bytes go out through the same guard as data bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ST_DATA;
      tx_word_q <= 16'h0000;
      ch_start  <= 1'b0;
      ch_data   <= 8'h00;
    end else begin
      ch_start <= ch_start_d;
      case (st_q)
        ST_DATA: begin
          if (take_data) begin
            ch_data   <= tx_data;
            tx_word_q <= csum_d;
            if (tx_last && gen_en && block_md)
              st_q <= crc_md ? ST_CHI : ST_CLO;
          end
        end
        ST_CHI: begin
          if (send_go) begin
            ch_data <= chk_byte;
            st_q    <= ST_CLO;
          end
        end
        ST_CLO: begin
          if (send_go) begin
            ch_data <= chk_byte;
            st_q    <= ST_DATA;
          end
        end
        default: st_q <= ST_DATA;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // checksum update
  // ----------------------------------------------------------------------
  // bytes arrive in direct convention, so the value is convention-free;
  // own check bytes are not folded in, leaving the sent word readable
  always @* begin
    csum_d = {csum_hi_q, csum_lo_q};
    if (take_data)
      csum_d = csum_step(csum_d, tx_data, crc_md);
    else if (rx_valid)
      csum_d = csum_step(csum_d, rx_data, crc_md);
  end
  // every received byte, check bytes included, goes to the fifo
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_valid <= 1'b0;
      rxf_data  <= 8'h00;
    end else begin
      rxf_valid <= rx_valid;
      if (rx_valid)
        rxf_data <= rx_data;
    end
  end
  // ----------------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------------
  // a software write to a checksum byte beats a hardware update, so a
  // seed load is never lost to traffic in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csum_hi_q  <= `SCEG_RST_CSUM_HI;
      csum_lo_q  <= `SCEG_RST_CSUM_LO;
      guard_q    <= `SCEG_RST_GUARD;
      spacing_q  <= `SCEG_RST_SPACING;
      bwait_q[0] <= `SCEG_RST_BWAIT;
      bwait_q[1] <= `SCEG_RST_BWAIT;
      bwait_q[2] <= `SCEG_RST_BWAIT;
      bwait_q[3] <= `SCEG_RST_BWAIT;
      ctl_q      <= `SCEG_RST_CTL;
    end else begin
      csum_hi_q <= csum_d[15:8];
      csum_lo_q <= csum_d[7:0];
      if (wr_en) begin
        case (idx)
          `SCEG_IDX_CSUM_HI: csum_hi_q  <= pwdata[7:0];
          `SCEG_IDX_CSUM_LO: csum_lo_q  <= pwdata[7:0];
          `SCEG_IDX_GUARD:   guard_q    <= pwdata[7:0];
          `SCEG_IDX_SPACING: spacing_q  <= pwdata[7:0];
          `SCEG_IDX_BWAIT3:  bwait_q[3] <= pwdata[7:0];
          `SCEG_IDX_BWAIT2:  bwait_q[2] <= pwdata[7:0];
          `SCEG_IDX_BWAIT1:  bwait_q[1] <= pwdata[7:0];
          `SCEG_IDX_BWAIT0:  bwait_q[0] <= pwdata[7:0];
          `SCEG_IDX_CTL:     ctl_q      <= pwdata[2:0];
          default:           ctl_q      <= ctl_q;
        endcase
      end
    end
  end
  assign block_wait_limit = {bwait_q[3][`SCEG_BWAIT3_HI:0], bwait_q[2],
                             bwait_q[1], bwait_q[0]};
  // read data is captured in the setup cycle, so zero wait states suffice
  assign pready = 1'b1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (idx)
        `SCEG_IDX_CSUM_HI: prdata <= {24'h000000, csum_hi_q};
        `SCEG_IDX_CSUM_LO: prdata <= {24'h000000, csum_lo_q};
        `SCEG_IDX_GUARD:   prdata <= {24'h000000, guard_q[7], 2'b00, guard_q[4:0]};
        `SCEG_IDX_SPACING: prdata <= {24'h000000, spacing_q};
        `SCEG_IDX_BWAIT3:  prdata <= {28'h0000000, bwait_q[3][3:0]};
        `SCEG_IDX_BWAIT2:  prdata <= {24'h000000, bwait_q[2]};
        `SCEG_IDX_BWAIT1:  prdata <= {24'h000000, bwait_q[1]};
        `SCEG_IDX_BWAIT0:  prdata <= {24'h000000, bwait_q[0]};
        `SCEG_IDX_CTL:     prdata <= {29'h0, ctl_q};
        `SCEG_IDX_STAT:    prdata <= {27'h0, first_q, guard_ok, st_q};
        default: begin
          prdata  <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end
endmodule // sceg_top

// ### verif/sceg_asserts.sv
// sceg_asserts.sv - port checks for sceg_top
// assumes: one pclk domain, presetn async active low
`timescale 1ns/1ps
module sceg_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [17:0] paddr,
  input wire        pslverr,
  input wire        etu_tick,
  input wire        card_clk,
  input wire        tx_valid,
  input wire [7:0]  tx_data,
  input wire        tx_ready,
  input wire        ch_ready,
  input wire        ch_start,
  input wire [7:0]  ch_data,
  input wire        rx_valid,
  input wire [7:0]  rx_data,
  input wire        rxf_valid,
  input wire [7:0]  rxf_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------
  // etu ticks since last start
  // ------------------------------
  // saturates so long idles stay legal; one tick of slack for the clear edge
  reg [3:0] gap_q;
  reg       seen_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= 4'h0;
      seen_q <= 1'b0;
    end else if (ch_start) begin
      gap_q  <= 4'h0;
      seen_q <= 1'b1;
    end else if (etu_tick && gap_q != 4'hF) begin
      gap_q <= gap_q + 4'h1;
    end
  end
  sequence s_take; tx_valid && tx_ready; endsequence
  sequence s_char; ch_start && ch_data == $past(tx_data); endsequence
  property p_take; s_take |=> s_char; endproperty
  property p_pulse; ch_start |=> !ch_start; endproperty
  property p_rxf; rx_valid && !(tx_valid && tx_ready) |=> rxf_valid && rxf_data == $past(rx_data); endproperty
  property p_rxsrc; rxf_valid |-> $past(rx_valid); endproperty
  property p_hold; !ch_ready |-> !tx_ready; endproperty
  property p_etu; etu_tick |=> !etu_tick; endproperty
  // gated on sampled reset so the edge that releases reset is not judged
  property p_cclk; presetn |=> card_clk != $past(card_clk); endproperty
  property p_gap; ch_start && seen_q |-> gap_q >= 4'hA; endproperty
  property p_err; psel && !penable && paddr[17:2] == 16'h0000 |=> pslverr; endproperty
  a_take: assert property (p_take) else $error("taken byte not started");
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  a_rxf: assert property (p_rxf) else $error("fifo write missing");
  a_rxsrc: assert property (p_rxsrc) else $error("fifo write without byte");
  a_hold: assert property (p_hold) else $error("ready while uart busy");
  a_etu: assert property (p_etu) else $error("etu tick too long");
  a_cclk: assert property (p_cclk) else $error("card clock not half rate");
  a_gap: assert property (p_gap) else $error("start bits too close");
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule // sceg_asserts

bind sceg_top sceg_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .etu_tick(etu_tick),
  .card_clk(card_clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .ch_ready(ch_ready), .ch_start(ch_start), .ch_data(ch_data), .rx_valid(rx_valid),
  .rx_data(rx_data), .rxf_valid(rxf_valid), .rxf_data(rxf_data));

// ### verif/sceg_card_model.sv
// sceg_card_model.sv - card and uart framer stand-in on the far side
// assumes: bench pulses send_go / brk_go for one cycle on pclk
`timescale 1ns/1ps
module sceg_card_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ch_start,
  input  wire [7:0] ch_data,
  input  wire       slow,
  input  wire       send_go,
  input  wire [7:0] send_byte,
  input  wire       brk_go,
  output logic      ch_ready,
  output logic      rx_start,
  output logic      rx_valid,
  output logic [7:0] rx_data,
  output logic      break_det
);
  logic [7:0] got [0:31];
  int         n_got;
  logic [9:0] busy_q;
  // slow mode keeps the framer busy past the guard so ready gates sending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q    <= 10'h000;
      ch_ready  <= 1'b0;
      n_got     <= 0;
      rx_start  <= 1'b0;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
      break_det <= 1'b0;
    end else begin
      rx_start  <= send_go;
      rx_valid  <= rx_start;
      rx_data   <= rx_start ? send_byte : ~rx_data; // idle line never holds old byte
      break_det <= brk_go;
      if (ch_start) begin
        got[n_got] <= ch_data;
        n_got      <= n_got + 1;
        busy_q     <= slow ? 10'h1F4 : 10'h004;
      end else if (busy_q != 10'h000) begin
        busy_q <= busy_q - 10'h001;
      end
      ch_ready <= (busy_q == 10'h000) && !ch_start;
    end
  end
endmodule // sceg_card_model

// ### verif/sceg_top_tb.sv
// sceg_top_tb.sv - register, etu, checksum and guard tests for sceg_top
// assumes: sceg_card_model on the far side, 8 ns pclk
`timescale 1ns/1ps
module sceg_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  fi_code, di_code;
  logic        etu_tick, card_clk, tx_valid, tx_last, tx_ready, ch_ready, ch_start;
  logic        rx_start, rx_valid, break_det, rxf_valid, slow, send_go, brk_go, e;
  logic [7:0]  tx_data, ch_data, rx_data, rxf_data, send_byte, b;
  logic [27:0] block_wait_limit;
  logic [15:0] c, k;
  int          err_total, total_checks, cyc, etu_n, st_etu, e0, eb, n;
  logic [7:0]  rv [8] = '{8'hFF, 8'hFF, 8'h10, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  bw [4] = '{8'hAB, 8'h12, 8'h34, 8'h56};

  sceg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fi_code(fi_code), .di_code(di_code), .etu_tick(etu_tick),
    .card_clk(card_clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .ch_ready(ch_ready), .ch_start(ch_start), .ch_data(ch_data),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data), .break_det(break_det),
    .rxf_valid(rxf_valid), .rxf_data(rxf_data), .block_wait_limit(block_wait_limit));
  sceg_card_model u_card (.pclk(pclk), .presetn(presetn), .ch_start(ch_start),
    .ch_data(ch_data), .slow(slow), .send_go(send_go), .send_byte(send_byte),
    .brk_go(brk_go), .ch_ready(ch_ready), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_data(rx_data), .break_det(break_det));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // etu count, start stamps and the hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (etu_tick === 1'b1) etu_n <= etu_n + 1;
    if (ch_start === 1'b1) st_etu <= etu_n;
    if (cyc == 90000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // apb transfer; idle cycle after so psel never rewrites in one step
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [15:0] i, input logic [7:0] x);
    apb(1'b0, i, 32'h0);
    chk({24'h0, x}, d);
  endtask
  task automatic rd16(input logic [15:0] x);
    rdchk(16'hFE14, x[15:8]);
    rdchk(16'hFE15, x[7:0]);
  endtask
  task automatic setup(input logic [2:0] m, input logic [15:0] s);
    apb(1'b1, 16'hFE30, {29'h0, m});
    apb(1'b1, 16'hFE14, {24'h0, s[15:8]});
    apb(1'b1, 16'hFE15, {24'h0, s[7:0]});
  endtask
  task automatic etu(input logic [3:0] f, input logic [3:0] dv, input logic [31:0] x);
    time t0;
    fi_code <= f;
    di_code <= dv;
    repeat (2) @(posedge etu_tick);
    t0 = $time;
    @(posedge etu_tick);
    chk(x, 32'(($time - t0) / 8));
  endtask
  task automatic msg(input int cnt, input logic [7:0] b0);
    for (int i = 0; i < cnt; i++) begin
      tx_valid <= 1'b1;
      tx_data  <= b0 + i[7:0];
      tx_last  <= (i == cnt - 1);
      @(posedge pclk);
      while (tx_ready !== 1'b1) @(posedge pclk);
    end
    tx_valid <= 1'b0;
  endtask
  task automatic rcv(input logic [7:0] x);
    send_byte <= x;
    send_go   <= 1'b1;
    e0 = etu_n;
    @(posedge pclk);
    send_go <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  // msb-first ccitt step, one byte
  function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] x);
    logic [15:0] r;
    r = s;
    for (int i = 7; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ x[i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction

  initial begin
    {psel, penable, pwrite, tx_valid, tx_last, slow, send_go, brk_go} = 8'h00;
    {paddr, pwdata, tx_data, send_byte} = 66'h0;
    {fi_code, di_code} = 8'h11;
    {err_total, total_checks, cyc, etu_n, st_etu} = 160'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdchk(16'hFE14 + i[15:0], rv[i]);
    apb(1'b0, 16'h0000, 32'h0);
    chk(32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++) apb(1'b1, 16'hFE18 + i[15:0], {24'h0, bw[i]});
    chk(32'h0B123456, {4'h0, block_wait_limit});
    rdchk(16'hFE18, 8'h0B);
    etu(4'h6, 4'h1, 32'd3720);
    etu(4'hD, 4'h1, 32'd4096);
    etu(4'h9, 4'h8, 32'd85);
    etu(4'h9, 4'h6, 32'd32);
    apb(1'b1, 16'hFE16, 32'h0C);
    apb(1'b1, 16'hFE17, 32'h05);
    // crc block send: two check bytes follow the last data byte
    setup(3'h7, 16'hFFFF);
    c = 16'hFFFF;
    for (int i = 0; i < 3; i++) c = crc(c, 8'h31 + i[7:0]);
    n = u_card.n_got;
    msg(3, 8'h31);
    wait (u_card.n_got == n + 5);
    chk({24'h0, c[15:8]}, {24'h0, u_card.got[n+3]});
    chk({24'h0, c[7:0]}, {24'h0, u_card.got[n+4]});
    rd16(c);
    // receive the same frame back, check bytes included
    setup(3'h7, 16'hFFFF);
    k = 16'hFFFF;
    for (int i = 0; i < 5; i++) begin
      b = (i < 3) ? 8'h31 + i[7:0] : ((i == 3) ? c[15:8] : c[7:0]);
      k = crc(k, b);
      rcv(b);
    end
    rd16(k);
    // turnaround after receive, generation off
    setup(3'h2, 16'hFFFF);
    n = u_card.n_got;
    msg(1, 8'h5A);
    repeat (500) @(posedge pclk);
    chk(n + 1, u_card.n_got);
    chk(32'h1, {31'h0, (st_etu - e0) >= 11});
    rd16(crc(16'hFFFF, 8'h5A));
    // lrc block send with a slow framer
    setup(3'h5, 16'hFF00);
    slow <= 1'b1;
    n = u_card.n_got;
    msg(3, 8'hA0);
    wait (u_card.n_got == n + 4);
    chk({24'h0, 8'hA0 ^ 8'hA1 ^ 8'hA2}, {24'h0, u_card.got[n+3]});
    rdchk(16'hFE15, 8'hA0 ^ 8'hA1 ^ 8'hA2);
    // break in character mode pushes the next start out
    setup(3'h0, 16'hFFFF);
    slow <= 1'b0;
    n = u_card.n_got;
    msg(1, 8'h11);
    repeat (256) @(posedge pclk);
    brk_go <= 1'b1;
    eb = etu_n;
    @(posedge pclk);
    brk_go <= 1'b0;
    msg(1, 8'h22);
    wait (u_card.n_got == n + 2);
    @(posedge pclk);
    chk(32'h1, {31'h0, (st_etu - eb) >= 11});
    end_sim();
  end
endmodule // sceg_top_tb
